//--- logic/scp_defines.svh
/*
  Constants of the serial configuration port: register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from any file that needs them.
*/
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// Register offsets
`define SCP_OFS_PORT_CFG 15'h0000
`define SCP_OFS_CHIP_TYPE 15'h0003
`define SCP_OFS_PROD_LO 15'h0004
`define SCP_OFS_PROD_HI 15'h0005
`define SCP_OFS_REVISION 15'h0006
`define SCP_OFS_POWER_DOWN 15'h0011
`define SCP_OFS_DUTY_CTRL 15'h0080
`define SCP_OFS_ALIGN_CTRL 15'h0081
`define SCP_OFS_BANDGAP 15'h01CD
`define SCP_OFS_TUNING_UPD 15'h0113

// Port configuration fields, mirrored pairs
`define SCP_CFG_RST_HI 7
`define SCP_CFG_RST_LO 0
`define SCP_CFG_LSB_HI 6
`define SCP_CFG_LSB_LO 1
`define SCP_CFG_INC_HI 5
`define SCP_CFG_INC_LO 2
`define SCP_CFG_SDO_HI 4
`define SCP_CFG_SDO_LO 3

// Other fields
`define SCP_DUTY_EN_BIT 2
`define SCP_ALIGN_PD_BIT 4
`define SCP_TUNING_REQ_BIT 0

// Reset values
`define SCP_RST_PORT_CFG 8'h00
`define SCP_RST_POWER_DOWN 8'h00
`define SCP_RST_DUTY_CTRL 8'h00
`define SCP_RST_ALIGN_CTRL 8'h00
`define SCP_RST_BANDGAP 8'h00

// Frame counts
`define SCP_INSTR_LAST 4'hF
`define SCP_BYTE_LAST 4'h7

// Timing
`define SCP_SCLK_MAX_MHZ 10
`define SCP_CLK_MHZ 25
`define SCP_SCLK_MIN_CYCLES ((`SCP_CLK_MHZ + `SCP_SCLK_MAX_MHZ - 1) / `SCP_SCLK_MAX_MHZ)

`endif

//--- logic/scp_pkg.sv
/*
  Types of the serial configuration port.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package scp_pkg;

  typedef enum logic [1:0] {
    SCP_PH_IDLE  = 2'b00,
    SCP_PH_INSTR = 2'b01,
    SCP_PH_DATA  = 2'b10
  } scp_phase_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
  } scp_pins_t;

  typedef struct packed {
    logic bandgap_pd;
    logic [1:0] converter_power_down;
    logic digital_clk_pd;
    logic [1:0] channel_clock_power_down;
    logic parallel_clk_pd;
    logic clk_receiver_pd;
  } scp_power_t;

  typedef struct packed {
    scp_phase_t phase;
    logic [3:0] bcnt;
    logic [15:0] shreg;
    logic rw;
    logic [14:0] addr;
    logic [7:0] rd_byte;
    logic out_bit;
    logic sclk_prev;
    logic [7:0] port_cfg;
    scp_power_t power_down;
    logic [7:0] duty_ctrl;
    logic [7:0] align_ctrl;
    logic [7:0] bandgap;
    logic tuning_req;
  } scp_state_t;

endpackage

`default_nettype wire

//--- logic/scp_sync.sv
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes inputs asynchronous to clock_i; only stage two is read outside.
*/
`default_nettype none

module scp_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Levels
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

`default_nettype wire

//--- logic/scp_core.sv
/*
  Serial configuration port: pin-level slave with its register file.
  Assumes the host drives serial clock, chip select and data as a serial
  master no faster than the device clock allows; pins are asynchronous.
*/
`include "scp_defines.svh"
`default_nettype none

module scp_core
  import scp_pkg::*;
#(
  parameter logic [7:0] CHIP_TYPE = 8'h5A,      // Arbitrary value
  parameter logic [15:0] PRODUCT_CODE = 16'hA5C3, // Arbitrary value
  parameter logic [4:0] REVISION = 5'h11        // Arbitrary value
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Serial pins from host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  // Serial pins to host
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // Configuration outputs
  output var scp_power_t power_down_o,
  output logic duty_correction_en_o,
  output logic alignment_input_power_down_o,
  output logic [7:0] bandgap_trim_o,
  output logic tuning_word_update_request_o
);

  scp_state_t s_q;
  scp_state_t s_d;
  scp_pins_t pin;
  logic rise;
  logic fall;
  logic lsb_first;
  logic addr_inc;
  logic four_wire;
  logic read_drive;
  logic [15:0] shifted;
  logic [7:0] data_byte;

  scp_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .d_i({sclk_i, cs_n_i, sdio_i}),
    .q_o(pin)
  );

  function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic b,
                                           input logic lsb);
    if (lsb) begin
      shift_in = {b, sr[15:1]};
    end else begin
      shift_in = {sr[14:0], b};
    end
  endfunction

  function automatic logic [7:0] read_reg(input logic [14:0] a, input scp_state_t st);
    case (a)
      `SCP_OFS_PORT_CFG: read_reg = st.port_cfg;
      `SCP_OFS_CHIP_TYPE: read_reg = CHIP_TYPE;
      `SCP_OFS_PROD_LO: read_reg = PRODUCT_CODE[7:0];
      `SCP_OFS_PROD_HI: read_reg = PRODUCT_CODE[15:8];
      `SCP_OFS_REVISION: read_reg = {3'h0, REVISION};
      `SCP_OFS_POWER_DOWN: read_reg = st.power_down;
      `SCP_OFS_DUTY_CTRL: read_reg = st.duty_ctrl;
      `SCP_OFS_ALIGN_CTRL: read_reg = st.align_ctrl;
      `SCP_OFS_BANDGAP: read_reg = st.bandgap;
      default: read_reg = 8'h00;
    endcase
  endfunction

  function automatic logic [14:0] next_addr(input logic [14:0] a, input logic inc);
    if (inc) begin
      next_addr = a + 15'h0001;
    end else begin
      next_addr = a - 15'h0001;
    end
  endfunction

  // Mirrored pairs: either bit of a pair selects the option
  assign lsb_first = s_q.port_cfg[`SCP_CFG_LSB_HI] | s_q.port_cfg[`SCP_CFG_LSB_LO];
  assign addr_inc = s_q.port_cfg[`SCP_CFG_INC_HI] | s_q.port_cfg[`SCP_CFG_INC_LO];
  assign four_wire = s_q.port_cfg[`SCP_CFG_SDO_HI] | s_q.port_cfg[`SCP_CFG_SDO_LO];

  // Edges of the sampled serial clock
  assign rise = pin.sclk & ~s_q.sclk_prev;
  assign fall = ~pin.sclk & s_q.sclk_prev;

  // Bit order and byte extraction
  assign shifted = shift_in(s_q.shreg, pin.sdio, lsb_first);
  assign data_byte = lsb_first ? shifted[15:8] : shifted[7:0];

  always_comb begin
    s_d = s_q;
    s_d.tuning_req = 1'b0;
    s_d.sclk_prev = pin.sclk;
    if (pin.cs_n) begin
      // Chip select high abandons any frame
      s_d.phase = SCP_PH_IDLE;
      s_d.bcnt = 4'h0;
    end else begin
      if (s_q.phase == SCP_PH_IDLE) begin
        s_d.phase = SCP_PH_INSTR;
      end
      if (rise) begin
        s_d.shreg = shifted;
        s_d.bcnt = s_q.bcnt + 4'h1;
        if (s_q.phase != SCP_PH_DATA) begin
          if (s_q.bcnt == `SCP_INSTR_LAST) begin
            // Instruction complete
            s_d.phase = SCP_PH_DATA;
            s_d.bcnt = 4'h0;
            s_d.rw = shifted[15];
            s_d.addr = shifted[14:0];
            s_d.rd_byte = read_reg(shifted[14:0], s_q);
          end
        end else if (s_q.bcnt == `SCP_BYTE_LAST) begin
          // Byte complete
          s_d.bcnt = 4'h0;
          if (!s_q.rw) begin
            case (s_q.addr)
              `SCP_OFS_PORT_CFG: begin
                if (data_byte[`SCP_CFG_RST_HI] | data_byte[`SCP_CFG_RST_LO]) begin
                  // Soft reset returns all writable registers to defaults
                  s_d.port_cfg = `SCP_RST_PORT_CFG;
                  s_d.power_down = `SCP_RST_POWER_DOWN;
                  s_d.duty_ctrl = `SCP_RST_DUTY_CTRL;
                  s_d.align_ctrl = `SCP_RST_ALIGN_CTRL;
                  s_d.bandgap = `SCP_RST_BANDGAP;
                end else begin
                  s_d.port_cfg = data_byte;
                end
              end
              `SCP_OFS_POWER_DOWN: s_d.power_down = data_byte;
              `SCP_OFS_DUTY_CTRL: s_d.duty_ctrl = data_byte;
              `SCP_OFS_ALIGN_CTRL: s_d.align_ctrl = data_byte;
              `SCP_OFS_BANDGAP: s_d.bandgap = data_byte;
              `SCP_OFS_TUNING_UPD: s_d.tuning_req = data_byte[`SCP_TUNING_REQ_BIT];
              default: s_d.tuning_req = 1'b0;
            endcase
          end
          s_d.addr = next_addr(s_q.addr, addr_inc);
          s_d.rd_byte = read_reg(next_addr(s_q.addr, addr_inc), s_q);
        end
      end
      if (fall && s_q.phase == SCP_PH_DATA) begin
        if (lsb_first) begin
          s_d.out_bit = s_q.rd_byte[s_q.bcnt[2:0]];
        end else begin
          s_d.out_bit = s_q.rd_byte[3'h7 - s_q.bcnt[2:0]];
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '{
        phase: SCP_PH_IDLE,
        bcnt: 4'h0,
        shreg: 16'h0000,
        rw: 1'b0,
        addr: 15'h0000,
        rd_byte: 8'h00,
        out_bit: 1'b0,
        sclk_prev: 1'b0,
        port_cfg: `SCP_RST_PORT_CFG,
        power_down: `SCP_RST_POWER_DOWN,
        duty_ctrl: `SCP_RST_DUTY_CTRL,
        align_ctrl: `SCP_RST_ALIGN_CTRL,
        bandgap: `SCP_RST_BANDGAP,
        tuning_req: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // Read data drive, only inside a read data phase
  assign read_drive = ~pin.cs_n & (s_q.phase == SCP_PH_DATA) & s_q.rw;
  assign sdio_o = s_q.out_bit;
  assign sdio_oe_o = read_drive & ~four_wire;
  assign serial_data_out_o = s_q.out_bit;
  assign serial_data_out_oe_o = read_drive & four_wire;

  // Configuration outputs
  assign power_down_o = s_q.power_down;
  assign duty_correction_en_o = s_q.duty_ctrl[`SCP_DUTY_EN_BIT];
  assign alignment_input_power_down_o = s_q.align_ctrl[`SCP_ALIGN_PD_BIT];
  assign bandgap_trim_o = s_q.bandgap;
  assign tuning_word_update_request_o = s_q.tuning_req;

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence byte_end_s;
    rise && !pin.cs_n && s_q.phase == SCP_PH_DATA && s_q.bcnt == `SCP_BYTE_LAST;
  endsequence

  sequence instr_end_s;
    rise && !pin.cs_n && s_q.phase == SCP_PH_INSTR && s_q.bcnt == `SCP_INSTR_LAST;
  endsequence

  sequence soft_reset_write_s;
    byte_end_s ##0 (!s_q.rw && s_q.addr == `SCP_OFS_PORT_CFG
                    && data_byte[`SCP_CFG_RST_HI]);
  endsequence

  idle_release_a: assert property (
    pin.cs_n |-> !sdio_oe_o && !serial_data_out_oe_o)
    else $error("data pins driven while chip select high");

  four_wire_pin_a: assert property (
    four_wire |-> !sdio_oe_o)
    else $error("shared data pin driven in four-wire mode");

  three_wire_pin_a: assert property (
    !four_wire |-> !serial_data_out_oe_o)
    else $error("separate output driven in three-wire mode");

  bit_count_a: assert property (
    (rise && !pin.cs_n && s_q.phase == SCP_PH_DATA && s_q.bcnt != `SCP_BYTE_LAST)
    |=> s_q.bcnt == $past(s_q.bcnt) + 4'h1)
    else $error("data bit not counted on serial clock rise");

  out_on_fall_a: assert property (
    $changed(s_q.out_bit) |-> $past(fall))
    else $error("read bit changed away from a falling edge");

  instr_to_data_a: assert property (
    instr_end_s |=> s_q.phase == SCP_PH_DATA && s_q.bcnt == 4'h0
                    && s_q.addr == $past(shifted[14:0]))
    else $error("instruction word not closed after sixteen rises");

  addr_step_a: assert property (
    (byte_end_s ##0 addr_inc) |=> s_q.addr == $past(s_q.addr) + 15'h0001)
    else $error("burst address did not increment");

  addr_down_a: assert property (
    (byte_end_s ##0 !addr_inc) |=> s_q.addr == $past(s_q.addr) - 15'h0001)
    else $error("burst address did not decrement");

  cs_restart_a: assert property (
    (pin.cs_n ##1 !pin.cs_n) |-> (s_q.phase == SCP_PH_IDLE && s_q.bcnt == 4'h0)
                                 ##1 (s_q.phase == SCP_PH_INSTR))
    else $error("chip select did not restart the frame");

  soft_reset_a: assert property (
    soft_reset_write_s |=> s_q.port_cfg == `SCP_RST_PORT_CFG
                           && s_q.power_down == `SCP_RST_POWER_DOWN)
    else $error("soft reset did not restore defaults");

  chip_type_a: assert property (
    (instr_end_s ##0 shifted[14:0] == `SCP_OFS_CHIP_TYPE) |=> s_q.rd_byte == CHIP_TYPE)
    else $error("product type read wrong");

  duty_write_a: assert property (
    (byte_end_s ##0 (!s_q.rw && s_q.addr == `SCP_OFS_DUTY_CTRL))
    |=> duty_correction_en_o == $past(data_byte[`SCP_DUTY_EN_BIT]))
    else $error("written byte not applied on its last bit");

endmodule

`default_nettype wire

//--- verification/scp_host_model.sv
/*
  Serial master model: chip select, serial clock and the shared data pin.
  Assumes the device answers on the shared pin or on its separate output.
*/
`default_nettype none

module scp_host_model (
  // Pins to device
  output logic sclk_o,
  output logic cs_n_o,
  output logic wire_o,
  // Pins from device
  input wire logic dev_sdio_i,
  input wire logic dev_oe_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv, bit_q, lsb, four;
  int oe_bad;
  logic [7:0] rd_q[$];

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    drv = 1'b0;
    bit_q = 1'b0;
    lsb = 1'b0;
    four = 1'b0;
    oe_bad = 0;
  end

  // Wire level: host, else device, else drifting
  always_comb wire_o = drv ? bit_q : (dev_oe_i ? dev_sdio_i : ~bit_q);

  task automatic frame(input logic rw, input logic [14:0] a,
                       input logic [7:0] wd[$], input int nbits);
    logic [15:0] iw;
    logic [7:0] b;
    int j;
    iw = {rw, a};
    rd_q = {};
    cs_n_o = 1'b0;
    for (int i = 0; i < 16 + nbits; i++) begin
      j = lsb ? i % 8 : 7 - i % 8;
      if (i < 16) begin
        drv = 1'b1;
        bit_q = iw[lsb ? i : 15 - i];
      end else if (rw) begin
        drv = 1'b0;
      end else begin
        bit_q = wd[(i - 16) / 8][j];
      end
      #160 sclk_o = 1'b1;
      #80;
      if (!rw || i < 16) begin
        if (dev_oe_i !== 1'b0 || sdo_oe_i !== 1'b0) oe_bad++;
      end else begin
        b[j] = four ? (sdo_oe_i ? sdo_i : ~sdo_i) : wire_o;
        if ((four ? sdo_oe_i : dev_oe_i) !== 1'b1) oe_bad++;
        if ((four ? dev_oe_i : sdo_oe_i) !== 1'b0) oe_bad++;
        if (i % 8 == 7) rd_q.push_back(b);
      end
      #80 sclk_o = 1'b0;
    end
    #160 cs_n_o = 1'b1;
    drv = 1'b0;
    #400;
    if (dev_oe_i !== 1'b0 || sdo_oe_i !== 1'b0) oe_bad++;
  endtask
endmodule

`default_nettype wire

//--- verification/scp_core_tb.sv
/*
  Testbench of the serial configuration port, driven by a host model.
  Assumes the design files and the host model are compiled before it.
*/
`default_nettype none

module scp_core_tb;
  import scp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CT = 8'h3A; // Arbitrary value
  localparam logic [15:0] PC = 16'h6B1E; // Arbitrary value
  localparam logic [4:0] RV = 5'h0D; // Arbitrary value
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sclk, cs_n, sdio, dsdio, doe, serial_data_out, sdo_oe, duty, align, tun;
  logic [7:0] bg, v, w;
  scp_power_t pd;
  int bad_count = 0;
  int checked = 0;
  int pulses = 0;
  int r;

  scp_core #(.CHIP_TYPE(CT), .PRODUCT_CODE(PC), .REVISION(RV)) dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdio_i(sdio), .sdio_o(dsdio), .sdio_oe_o(doe), .serial_data_out_o(serial_data_out),
    .serial_data_out_oe_o(sdo_oe), .power_down_o(pd), .duty_correction_en_o(duty),
    .alignment_input_power_down_o(align), .bandgap_trim_o(bg),
    .tuning_word_update_request_o(tun)
  );

  scp_host_model hst (
    .sclk_o(sclk), .cs_n_o(cs_n), .wire_o(sdio), .dev_sdio_i(dsdio),
    .dev_oe_i(doe), .sdo_i(serial_data_out), .sdo_oe_i(sdo_oe)
  );

  always #20 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    if (tun === 1'b1) pulses++;
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d[$]);
    @(posedge clock_i);
    #1;
    hst.frame(1'b0, a, d, 8 * d.size());
  endtask

  task automatic rd(input logic [14:0] a, input int n);
    logic [7:0] z[$];
    @(posedge clock_i);
    #1;
    hst.frame(1'b1, a, z, 8 * n);
  endtask

  task automatic final_report;
    $display("Counts: checked %0d, bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    bad_count++;
    final_report();
  end

  initial begin
    r = $urandom(46669);
    repeat (2) @(posedge clock_i);
    #1 arst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    #1;
    check8(8'(pd), 8'h00);
    check8({5'h0, duty, align, doe}, 8'h00);
    // Three-wire decrementing burst over chip information
    rd(15'h0006, 4);
    check8(hst.rd_q[0] & 8'h1F, {3'h0, RV});
    check8(hst.rd_q[1], PC[15:8]);
    check8(hst.rd_q[2], PC[7:0]);
    check8(hst.rd_q[3], CT);
    wr(15'h0003, {~CT});
    rd(15'h0003, 1);
    check8(hst.rd_q[0], CT);
    rd(15'h7FFF, 1);
    check8(hst.rd_q[0], 8'h00);
    // Soft reset, then four-wire incrementing
    wr(15'h0080, {8'h04});
    check8({7'h0, duty}, 8'h01);
    wr(15'h0000, {8'hBD});
    check8({7'h0, duty}, 8'h00);
    rd(15'h0000, 1);
    check8(hst.rd_q[0], 8'h00);
    wr(15'h0000, {8'h3C});
    hst.four = 1'b1;
    rd(15'h0000, 1);
    check8(hst.rd_q[0], 8'h3C);
    wr(15'h0080, {8'h04, 8'h10});
    check8({6'h0, duty, align}, 8'h03);
    rd(15'h0080, 2);
    check8(hst.rd_q[0], 8'h04);
    check8(hst.rd_q[1], 8'h10);
    wr(15'h01CD, {8'hD8});
    check8(bg, 8'hD8);
    // Random traffic, switching to LSB-first midway
    for (int k = 0; k < 6; k++) begin
      v = 8'($urandom);
      w = 8'($urandom);
      wr(15'h0011, {v});
      check8(8'(pd), v);
      wr(15'h01CD, {w});
      check8(bg, w);
      rd(15'h0011, 1);
      check8(hst.rd_q[0], v);
      hst.frame(1'b0, 15'h0011, {~v}, 5);
      check8(8'(pd), v);
      if (k == 2) begin
        wr(15'h0000, {8'h7E});
        hst.lsb = 1'b1;
      end
    end
    rd(15'h0000, 1);
    check8(hst.rd_q[0], 8'h7E);
    wr(15'h0113, {8'h01});
    wr(15'h0113, {8'h00});
    check8(8'(pulses), 8'h01);
    check8(8'(hst.oe_bad), 8'h00);
    final_report();
  end
endmodule

`default_nettype wire
